// file: design/haptic_waveform_timing_offsets.sv
`default_nettype none

`include "haptic_timing_consts.svh"

// Notes on behaviour
// - Overdrive offset is signed 8-bit, scaled by 5 ms steps.
// - Samples at the waveform's largest level form the overdrive segment.
// - Overdrive offset applies in open loop only.
// - Positive sustain offset is signed 8-bit, scaled by 5 ms steps.
// - Other positive levels are positive sustain, adjusted by its offset.
// - Negative sustain offset is signed 8-bit, scaled by 5 ms steps.
// - Other negative levels are negative sustain, adjusted by its offset.
// - Brake offset is signed 8-bit, scaled by 5 ms steps.
// - Samples at the most negative level form the braking segment.
// - Brake offset applies in open loop only.
// - Rated level resets to 0x3f, is closed-loop full scale and calibration input.
// - Open loop uses the drive level clamp as full scale instead.
// - Four time offset registers are read/write and reset to zero.
module haptic_waveform_timing_offsets
  import haptic_timing_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `SEG_STEP_CYCLES
)
(
  // Clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  // Register access from the serial control front end
  input wire haptic_timing_pkg::reg_req_t I_REG,
  output logic [7:0] O_REG_RDATA,
  output logic O_REG_RVALID,
  // Drive mode
  input wire logic I_CLOSED_LOOP,
  // Segment request from the playback engine
  input wire logic I_SEG_VALID,
  input wire haptic_timing_pkg::seg_req_t I_SEG,
  output logic O_SEG_READY,
  // Segment timing result
  output haptic_timing_pkg::seg_class_t O_SEG_CLASS,
  output logic [`ADJ_UNITS_W-1:0] O_SEG_ADJ_UNITS,
  output logic O_SEG_ACTIVE,
  output logic O_SEG_DONE,
  // References
  output logic [7:0] O_FULL_SCALE,
  output logic [7:0] O_CAL_RATED_LEVEL
);
  import haptic_timing_pkg::*;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] overdrive_time_adjust_r;
  logic [7:0] positive_sustain_time_adjust_r;
  logic [7:0] negative_sustain_time_adjust_r;
  logic [7:0] brake_time_adjust_r;
  logic [7:0] full_scale_reference_level_r;
  logic [7:0] drive_level_clamp_r;

  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      overdrive_time_adjust_r <= `RST_TIME_ADJUST;
      positive_sustain_time_adjust_r <= `RST_TIME_ADJUST;
      negative_sustain_time_adjust_r <= `RST_TIME_ADJUST;
      brake_time_adjust_r <= `RST_TIME_ADJUST;
      full_scale_reference_level_r <= `RST_FULL_SCALE_REF_LEVEL;
      drive_level_clamp_r <= `RST_DRIVE_LEVEL_CLAMP;
    end
    else if (I_REG.wr)
    begin
      unique case (I_REG.addr)
        `ADDR_OVERDRIVE_TIME_ADJUST:
          overdrive_time_adjust_r <= I_REG.wdata;
        `ADDR_POS_SUSTAIN_TIME_ADJUST:
          positive_sustain_time_adjust_r <= I_REG.wdata;
        `ADDR_NEG_SUSTAIN_TIME_ADJUST:
          negative_sustain_time_adjust_r <= I_REG.wdata;
        `ADDR_BRAKE_TIME_ADJUST:
          brake_time_adjust_r <= I_REG.wdata;
        `ADDR_FULL_SCALE_REF_LEVEL:
          full_scale_reference_level_r <= I_REG.wdata;
        `ADDR_DRIVE_LEVEL_CLAMP:
          drive_level_clamp_r <= I_REG.wdata;
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rdata_nxt;

  always_comb
  begin
    unique case (I_REG.addr)
      `ADDR_OVERDRIVE_TIME_ADJUST: rdata_nxt = overdrive_time_adjust_r;
      `ADDR_POS_SUSTAIN_TIME_ADJUST:
        rdata_nxt = positive_sustain_time_adjust_r;
      `ADDR_NEG_SUSTAIN_TIME_ADJUST:
        rdata_nxt = negative_sustain_time_adjust_r;
      `ADDR_BRAKE_TIME_ADJUST: rdata_nxt = brake_time_adjust_r;
      `ADDR_FULL_SCALE_REF_LEVEL: rdata_nxt = full_scale_reference_level_r;
      `ADDR_DRIVE_LEVEL_CLAMP: rdata_nxt = drive_level_clamp_r;
      default: rdata_nxt = `RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_REG_RDATA <= `RDATA_UNMAPPED;
      O_REG_RVALID <= 1'b0;
    end
    else
    begin
      O_REG_RVALID <= I_REG.rd;
      if (I_REG.rd)
      begin
        O_REG_RDATA <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Full-scale reference selection
  // ----------------------------------------------------------------
  // Rated level is also fed to calibration whatever the loop mode
  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_FULL_SCALE <= `RST_FULL_SCALE_REF_LEVEL;
      O_CAL_RATED_LEVEL <= `RST_FULL_SCALE_REF_LEVEL;
    end
    else
    begin
      O_CAL_RATED_LEVEL <= full_scale_reference_level_r;
      if (I_CLOSED_LOOP)
      begin
        O_FULL_SCALE <= full_scale_reference_level_r;
      end
      else
      begin
        O_FULL_SCALE <= drive_level_clamp_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // Segment classification and offset selection
  // ----------------------------------------------------------------
  seg_class_t class_nxt;
  logic [7:0] offset_sel;

  // Extremes are checked first so a peak never counts as sustain
  always_comb
  begin
    if (I_SEG.level > 8'sh00 && I_SEG.level == I_SEG.wave_max)
    begin
      class_nxt = SEG_OVERDRIVE;
    end
    else if (I_SEG.level < 8'sh00 && I_SEG.level == I_SEG.wave_min)
    begin
      class_nxt = SEG_BRAKE;
    end
    else if (I_SEG.level > 8'sh00)
    begin
      class_nxt = SEG_POS_SUSTAIN;
    end
    else if (I_SEG.level < 8'sh00)
    begin
      class_nxt = SEG_NEG_SUSTAIN;
    end
    else
    begin
      class_nxt = SEG_NONE;
    end
  end

  // Closed loop makes its own overdrive and braking
  always_comb
  begin
    unique case (class_nxt)
      SEG_OVERDRIVE:
        offset_sel = I_CLOSED_LOOP ? `RST_TIME_ADJUST
                                   : overdrive_time_adjust_r;
      SEG_POS_SUSTAIN: offset_sel = positive_sustain_time_adjust_r;
      SEG_NEG_SUSTAIN: offset_sel = negative_sustain_time_adjust_r;
      SEG_BRAKE:
        offset_sel = I_CLOSED_LOOP ? `RST_TIME_ADJUST
                                   : brake_time_adjust_r;
      default: offset_sel = `RST_TIME_ADJUST;
    endcase
  end

  // ----------------------------------------------------------------
  // Duration adjust, in 5 ms steps
  // ----------------------------------------------------------------
  logic signed [`SUM_W-1:0] sum;
  logic [`ADJ_UNITS_W-1:0] adj_nxt;

  always_comb
  begin
    sum = signed'({2'b00, I_SEG.units})
          + `SUM_W'(signed'(offset_sel));
    if (sum < 0)
    begin
      adj_nxt = '0;
    end
    else
    begin
      adj_nxt = sum[`ADJ_UNITS_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Segment timer
  // ----------------------------------------------------------------
  seg_state_t state_r;
  logic [`STEP_CNT_W-1:0] step_cnt_r;
  logic [`ADJ_UNITS_W-1:0] units_left_r;
  logic step_tick;

  assign step_tick = (step_cnt_r == `STEP_CNT_W'(STEP_CYCLES - 1));

  always_ff @(posedge I_CLOCK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      state_r <= ST_IDLE;
      step_cnt_r <= '0;
      units_left_r <= '0;
      O_SEG_CLASS <= SEG_NONE;
      O_SEG_ADJ_UNITS <= '0;
      O_SEG_ACTIVE <= 1'b0;
      O_SEG_DONE <= 1'b0;
      O_SEG_READY <= 1'b0;
    end
    else
    begin
      O_SEG_DONE <= 1'b0;
      unique case (state_r)
        ST_IDLE:
        begin
          O_SEG_READY <= 1'b1;
          if (I_SEG_VALID && O_SEG_READY)
          begin
            O_SEG_READY <= 1'b0;
            O_SEG_CLASS <= class_nxt;
            O_SEG_ADJ_UNITS <= adj_nxt;
            units_left_r <= adj_nxt;
            step_cnt_r <= '0;
            O_SEG_ACTIVE <= 1'b1;
            state_r <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          // A segment clamped to zero ends without playing
          if (units_left_r == '0)
          begin
            O_SEG_ACTIVE <= 1'b0;
            O_SEG_DONE <= 1'b1;
            state_r <= ST_IDLE;
          end
          else if (step_tick)
          begin
            step_cnt_r <= '0;
            units_left_r <= units_left_r - 1'b1;
          end
          else
          begin
            step_cnt_r <= step_cnt_r + 1'b1;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: shared/haptic_timing_consts.svh
`ifndef HAPTIC_TIMING_CONSTS_SVH
`define HAPTIC_TIMING_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_OVERDRIVE_TIME_ADJUST 8'h0d
`define ADDR_POS_SUSTAIN_TIME_ADJUST 8'h0e
`define ADDR_NEG_SUSTAIN_TIME_ADJUST 8'h0f
`define ADDR_BRAKE_TIME_ADJUST 8'h10
`define ADDR_FULL_SCALE_REF_LEVEL 8'h16
`define ADDR_DRIVE_LEVEL_CLAMP 8'h17

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_TIME_ADJUST 8'h00
`define RST_FULL_SCALE_REF_LEVEL 8'h3f
`define RST_DRIVE_LEVEL_CLAMP 8'h89
`define RDATA_UNMAPPED 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_FREQ_KHZ 40000
`define SEG_STEP_MS 5
`define SEG_STEP_CYCLES (`SEG_STEP_MS * `CLK_FREQ_KHZ)

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define SEG_UNITS_W 12
`define ADJ_UNITS_W 13
`define SUM_W 14
`define STEP_CNT_W 18

`endif

// file: shared/haptic_timing_pkg.sv
`default_nettype none

`include "haptic_timing_consts.svh"

package haptic_timing_pkg;

  // One library waveform segment handed over by the playback engine
  typedef struct packed {
    logic signed [7:0] level;
    logic signed [7:0] wave_max;
    logic signed [7:0] wave_min;
    logic [`SEG_UNITS_W-1:0] units;
  } seg_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [2:0] {
    SEG_NONE,
    SEG_OVERDRIVE,
    SEG_POS_SUSTAIN,
    SEG_NEG_SUSTAIN,
    SEG_BRAKE
  } seg_class_t;

  typedef enum logic {
    ST_IDLE,
    ST_RUN
  } seg_state_t;

endpackage

`default_nettype wire

// file: test/haptic_waveform_timing_offsets_bench.sv
`default_nettype none
`include "haptic_timing_consts.svh"
module haptic_waveform_timing_offsets_bench import haptic_timing_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t req = '0;
  logic closed = 1'b0;
  logic seg_valid = 1'b0;
  seg_req_t seg = '0;
  logic [7:0] rdata, full_scale, cal_level;
  logic rvalid, ready, active, done;
  seg_class_t cls;
  logic [`ADJ_UNITS_W-1:0] adj;
  int errors = 0;
  int cmp_count = 0;
  always #12.5 clk = ~clk;
  // Short step keeps segment timing runs brief
  haptic_waveform_timing_offsets #(.STEP_CYCLES(4))
    haptic_waveform_timing_offsets_i (.I_CLOCK(clk), .I_RST_B(rst_b),
    .I_REG(req), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
    .I_CLOSED_LOOP(closed), .I_SEG_VALID(seg_valid), .I_SEG(seg),
    .O_SEG_READY(ready), .O_SEG_CLASS(cls), .O_SEG_ADJ_UNITS(adj),
    .O_SEG_ACTIVE(active), .O_SEG_DONE(done), .O_FULL_SCALE(full_scale),
    .O_CAL_RATED_LEVEL(cal_level));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic timeout();
    errors++;
    results();
  endtask
  // Ends one ns past the taking edge, where a read answer is settled
  task automatic reg_op(logic wr, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    reg_op(1'b0, a, 8'h00);
    check("rvalid", {15'h0000, rvalid}, 16'h0001);
    check("rdata", {8'h00, rdata}, {8'h00, e});
  endtask
  task automatic seg_run(logic [7:0] lv, logic [11:0] u, logic cl,
                         seg_class_t ec, logic [12:0] ea);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 100)
      timeout();
    @(posedge clk);
    seg <= '{level: lv, wave_max: 8'h64, wave_min: 8'h9c, units: u};
    seg_valid <= 1'b1;
    closed <= cl;
    @(posedge clk);
    seg_valid <= 1'b0;
    #1;
    check("class", {13'h0000, cls}, {13'h0000, ec});
    check("adj", {3'h0, adj}, {3'h0, ea});
    check("active", {15'h0000, active}, 16'h0001);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 200);
    if (n == 200)
      timeout();
    check("done_delay", n[15:0], {3'h0, ea} * 16'h0004 + 16'h0001);
    check("active_end", {15'h0000, active}, 16'h0000);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_regs();
    for (int i = 0; i < 4; i++)
      rd_chk(8'h0d + i[7:0], 8'h00);
    rd_chk(8'h16, 8'h3f);
    rd_chk(8'h17, 8'h89);
    rd_chk(8'h11, 8'h00);
    for (int i = 0; i < 4; i++)
      reg_op(1'b1, 8'h0d + i[7:0], 8'ha5 ^ i[7:0]);
    reg_op(1'b1, 8'h11, 8'h77);
    for (int i = 0; i < 4; i++)
      rd_chk(8'h0d + i[7:0], 8'ha5 ^ i[7:0]);
    rd_chk(8'h11, 8'h00);
    $display("test regs done");
  endtask
  task automatic test_scale();
    reg_op(1'b1, 8'h16, 8'h55);
    reg_op(1'b1, 8'h17, 8'h70);
    @(posedge clk);
    closed <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("fs_open", {8'h00, full_scale}, 16'h0070);
    @(posedge clk);
    closed <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check("fs_closed", {8'h00, full_scale}, 16'h0055);
    check("cal_level", {8'h00, cal_level}, 16'h0055);
    // Calibration input must follow a changed rated level
    reg_op(1'b1, 8'h16, 8'h4a);
    @(posedge clk);
    #1;
    check("cal_new", {8'h00, cal_level}, 16'h004a);
    check("fs_new", {8'h00, full_scale}, 16'h004a);
    $display("test scale done");
  endtask
  task automatic test_segs();
    reg_op(1'b1, 8'h0d, 8'h02);
    reg_op(1'b1, 8'h0e, 8'hff);
    reg_op(1'b1, 8'h0f, 8'h03);
    reg_op(1'b1, 8'h10, 8'hfb);
    seg_run(8'h64, 12'd3, 1'b0, SEG_OVERDRIVE, 13'd5);
    seg_run(8'h64, 12'd3, 1'b1, SEG_OVERDRIVE, 13'd3);
    seg_run(8'h32, 12'd2, 1'b0, SEG_POS_SUSTAIN, 13'd1);
    seg_run(8'h32, 12'd2, 1'b1, SEG_POS_SUSTAIN, 13'd1);
    seg_run(8'hce, 12'd1, 1'b0, SEG_NEG_SUSTAIN, 13'd4);
    seg_run(8'h9c, 12'd7, 1'b0, SEG_BRAKE, 13'd2);
    seg_run(8'h9c, 12'd2, 1'b1, SEG_BRAKE, 13'd2);
    seg_run(8'h9c, 12'd3, 1'b0, SEG_BRAKE, 13'd0);
    seg_run(8'h00, 12'd2, 1'b0, SEG_NONE, 13'd2);
    $display("test segs done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    test_regs();
    test_scale();
    test_segs();
    results();
  end
endmodule
`default_nettype wire

// file: test/haptic_waveform_timing_offsets_checker.sv
`default_nettype none
`include "haptic_timing_consts.svh"
module haptic_waveform_timing_offsets_checker
  import haptic_timing_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = 4
)
(
  // Clock, reset, register port
  input wire logic I_CLOCK,
  input wire logic I_RST_B,
  input wire haptic_timing_pkg::reg_req_t I_REG,
  input wire logic [7:0] O_REG_RDATA,
  input wire logic O_REG_RVALID,
  // Segment port and references
  input wire logic I_CLOSED_LOOP,
  input wire logic I_SEG_VALID,
  input wire haptic_timing_pkg::seg_req_t I_SEG,
  input wire logic O_SEG_READY,
  input wire haptic_timing_pkg::seg_class_t O_SEG_CLASS,
  input wire logic [`ADJ_UNITS_W-1:0] O_SEG_ADJ_UNITS,
  input wire logic O_SEG_ACTIVE,
  input wire logic O_SEG_DONE,
  input wire logic [7:0] O_FULL_SCALE,
  input wire logic [7:0] O_CAL_RATED_LEVEL
);
  logic acc;
  logic od_req;
  logic br_req;
  assign acc = I_SEG_VALID && O_SEG_READY;
  assign od_req = I_SEG.level > 0 && I_SEG.level == I_SEG.wave_max;
  assign br_req = I_SEG.level < 0 && I_SEG.level == I_SEG.wave_min;
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_B);
  a_rd_answer: assert property (I_REG.rd |=> O_REG_RVALID)
    else $error("read not answered");
  a_rvalid_cause: assert property (O_REG_RVALID |-> $past(I_REG.rd))
    else $error("read valid without read");
  a_fs_closed: assert property ($past(I_CLOSED_LOOP)
    && $stable(O_CAL_RATED_LEVEL) |-> O_FULL_SCALE == O_CAL_RATED_LEVEL)
    else $error("closed loop full scale wrong");
  a_od_class: assert property (acc && od_req
    |=> O_SEG_CLASS == SEG_OVERDRIVE) else $error("overdrive class");
  a_brake_class: assert property (acc && br_req
    |=> O_SEG_CLASS == SEG_BRAKE) else $error("brake class");
  a_pos_class: assert property (acc && I_SEG.level > 0 && !od_req
    |=> O_SEG_CLASS == SEG_POS_SUSTAIN) else $error("pos sustain class");
  a_neg_class: assert property (acc && I_SEG.level < 0 && !br_req
    |=> O_SEG_CLASS == SEG_NEG_SUSTAIN) else $error("neg sustain class");
  a_closed_fixed: assert property (acc && I_CLOSED_LOOP
    && (od_req || br_req) |=> O_SEG_ADJ_UNITS == $past(I_SEG.units))
    else $error("closed loop offset applied");
  a_zero_done: assert property ($rose(O_SEG_ACTIVE)
    && O_SEG_ADJ_UNITS == 0 |-> ##1 O_SEG_DONE) else $error("zero length");
endmodule
bind haptic_waveform_timing_offsets haptic_waveform_timing_offsets_checker
  #(.STEP_CYCLES(STEP_CYCLES)) haptic_waveform_timing_offsets_checker_i (
  .I_CLOCK(I_CLOCK),
  .I_RST_B(I_RST_B),
  .I_REG(I_REG),
  .O_REG_RDATA(O_REG_RDATA),
  .O_REG_RVALID(O_REG_RVALID),
  .I_CLOSED_LOOP(I_CLOSED_LOOP),
  .I_SEG_VALID(I_SEG_VALID),
  .I_SEG(I_SEG),
  .O_SEG_READY(O_SEG_READY),
  .O_SEG_CLASS(O_SEG_CLASS),
  .O_SEG_ADJ_UNITS(O_SEG_ADJ_UNITS),
  .O_SEG_ACTIVE(O_SEG_ACTIVE),
  .O_SEG_DONE(O_SEG_DONE),
  .O_FULL_SCALE(O_FULL_SCALE),
  .O_CAL_RATED_LEVEL(O_CAL_RATED_LEVEL)
);
`default_nettype wire
